// >>> primary_serial_port.sv
// Purpose: primary serial port, communication-equipment end, wb slave
// Assumes: sleep_i comes from sleep logic on the same clock
// Notes: one command path for local and cellular traffic
`timescale 1ns/1ns
`default_nettype none
module primary_serial_port #(
    parameter int clk_hz_p = sp_pkg::CLK_HZ
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sleep_i,
    input wire logic txd_n_i,
    input wire logic rts_n_i,
    input wire logic dtr_n_i,
    output logic rxd_n_o,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic carrier_present_out_n_o,
    output logic ring_indicate_out_n_o,
    output logic [7:0] cell_data_o,
    output logic cell_valid_o
);
    function automatic logic [16:0] bit_div(input logic [3:0] s);
        int q;
        q = clk_hz_p / sp_pkg::RATE_TAB[s];
        bit_div = q[16:0];
    endfunction

    function automatic logic [4:0] ab_pick(input logic [20:0] c);
        logic [20:0] th;
        ab_pick = 5'h0;
        for (int i = int'(sp_pkg::SEL_AUTO_MAX); i >= 0; i--)
        begin
            th = ({4'h0, bit_div(4'(i))} * sp_pkg::AB_NUM) >> sp_pkg::AB_SHIFT;
            if (c >= th)
            begin
                ab_pick = {1'b1, 4'(i)};
            end
        end
    endfunction

    function automatic logic [31:0] rd_mux(input logic [7:0] a,
        input logic [11:0] c, input logic [7:0] st, input logic [7:0] rx,
        input logic [2:0] m);
        if (a == sp_pkg::ADR_CTRL)
            rd_mux = {20'h0, c};
        else if (a == sp_pkg::ADR_STAT)
            rd_mux = {24'h0, st};
        else if (a == sp_pkg::ADR_RXD)
            rd_mux = {24'h0, rx};
        else if (a == sp_pkg::ADR_MODEM)
            rd_mux = {29'h0, m};
        else
            rd_mux = 32'h0;
    endfunction

    logic [2:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
    logic [11:0] ctrl_reg;
    // inverted copy so the modem pins leave straight from flops
    logic [2:0] modem_reg, mdm_n_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    sp_pkg::ab_t ab_reg;
    logic [20:0] ab_cnt_reg;
    sp_pkg::rx_st_t rx_st_reg;
    logic [16:0] rx_cnt_reg, tx_cnt_reg;
    logic [2:0] rx_bit_reg, tx_bit_reg;
    logic [7:0] rx_sh_reg, tx_sh_reg, tx_buf_reg, rx_buf_reg;
    logic rx_par_reg, tx_full_reg, tx_par_reg, xoff_reg;
    sp_pkg::tx_st_t tx_st_reg;
    logic rxd_reg, cts_reg, rxv_reg, perr_reg, ferr_reg, ovr_reg;
    sp_pkg::route_t route_reg;
    logic [31:0] pend_reg;
    logic [2:0] pcnt_reg;
    logic flush_reg, fl_loc_reg, cell_v_reg;
    logic [7:0] cell_d_reg;

    // three-stage sync; a change counts once stages two and three agree
    assign lvl_next = (~(s2_reg ^ s3_reg) & s3_reg)
        | ((s2_reg ^ s3_reg) & lvl_reg);
    wire rx_lin = lvl_reg[0];
    wire rts_lvl = lvl_reg[1];
    wire dtr_lvl = lvl_reg[2];
    wire port_on = !sleep_i;
    wire [3:0] sel = ctrl_reg[3:0];
    wire auto_on = ctrl_reg[sp_pkg::C_AUTO];
    wire [1:0] flow = ctrl_reg[sp_pkg::C_FLOW +: 2];
    wire [1:0] par = ctrl_reg[sp_pkg::C_PAR +: 2];
    wire par_on = par != 2'h0;
    wire par_odd = par == sp_pkg::PAR_ODD;
    wire stop2 = ctrl_reg[sp_pkg::C_STOP2];
    wire data7 = ctrl_reg[sp_pkg::C_DATA7];
    wire cellhost = ctrl_reg[sp_pkg::C_CELLHOST];
    wire sw_flow = flow == sp_pkg::FLOW_SW;
    wire [2:0] nb_m1 = data7 ? 3'h6 : 3'h7;
    wire [16:0] div = bit_div(sel);
    wire [20:0] idle_need = {4'h0, div} * sp_pkg::AB_IDLE_BITS;
    wire [4:0] pick = ab_pick(ab_cnt_reg);
    wire locked = ab_reg == sp_pkg::AB_DONE;

    // bus decode
    wire hit = wb_cyc_i && wb_stb_i && !ack_reg;
    wire [7:0] wadr = {wb_adr_i[7:2], 2'h0};
    wire wr = hit && wb_we_i;
    wire wr_ctrl = wr && wadr == sp_pkg::ADR_CTRL;
    wire wr_auto = wr_ctrl && wb_sel_i[0] && wb_dat_i[sp_pkg::C_AUTO];
    wire [3:0] sel_w = (wb_dat_i[3:0] > sp_pkg::SEL_MAX) ? sp_pkg::SEL_MAX
        : wb_dat_i[3:0];
    wire wr_stat = wr && wadr == sp_pkg::ADR_STAT && wb_sel_i[0];
    wire wr_txd = wr && wadr == sp_pkg::ADR_TXD && wb_sel_i[0];
    wire wr_mdm = wr && wadr == sp_pkg::ADR_MODEM && wb_sel_i[0];
    wire rd_rxd = hit && !wb_we_i && wadr == sp_pkg::ADR_RXD;
    wire [7:0] stat = {xoff_reg, sleep_i, ovr_reg, ferr_reg, perr_reg,
        locked, tx_full_reg || tx_st_reg != sp_pkg::TX_IDLE, rxv_reg};

    // receiver
    wire rx_go = port_on && (!auto_on || locked);
    wire rx_done = rx_go && rx_st_reg == sp_pkg::RX_STOP
        && rx_cnt_reg == 17'h0;
    wire [7:0] rx_data = data7 ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg;
    wire rx_perr = par_on && (rx_par_reg != (^rx_data ^ par_odd));
    wire is_xon = rx_data == sp_pkg::CH_XON;
    wire is_xoff = rx_data == sp_pkg::CH_XOFF;
    wire byte_in = rx_done && !(sw_flow && (is_xon || is_xoff));
    wire is_cr = rx_data == sp_pkg::CH_CR;
    wire cmd_ok = (rx_data | sp_pkg::CASE_BIT)
        == sp_pkg::CMD_PREFIX[{pcnt_reg[1:0], 3'h0} +: 8];
    wire dl_stb = flush_reg && pcnt_reg != 3'h0;

    // transmitter gate; the host keeps both lines low
    wire tx_ok = port_on && !dtr_lvl && !rts_lvl
        && !(sw_flow && xoff_reg);
    wire [7:0] tx_mask = data7 ? {1'b0, tx_buf_reg[6:0]} : tx_buf_reg;

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign rxd_n_o = rxd_reg;
    assign cts_n_o = cts_reg;
    assign dsr_n_o = mdm_n_reg[0];
    assign carrier_present_out_n_o = mdm_n_reg[1];
    assign ring_indicate_out_n_o = mdm_n_reg[2];
    assign cell_data_o = cell_d_reg;
    assign cell_valid_o = cell_v_reg;

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            s3_reg <= 3'h7;
            lvl_reg <= 3'h7;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
            modem_reg <= sp_pkg::MODEM_RST;
            mdm_n_reg <= ~sp_pkg::MODEM_RST;
            cts_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= {dtr_n_i, rts_n_i, txd_n_i};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            ack_reg <= hit;
            dat_reg <= rd_mux(wadr, ctrl_reg, stat, rx_buf_reg, modem_reg);
            if (wr_mdm)
            begin
                modem_reg <= wb_dat_i[2:0];
                mdm_n_reg <= ~wb_dat_i[2:0];
            end
            cts_reg <= !port_on || (flow == sp_pkg::FLOW_HW && rxv_reg);
        end
    end

    // ctrl register and rate detection share the rate field
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_reg <= sp_pkg::CTRL_RST;
            ab_reg <= sp_pkg::AB_MEAS;
            ab_cnt_reg <= 21'h0;
        end
        else if (wr_ctrl)
        begin
            if (wb_sel_i[0])
                ctrl_reg[7:0] <= {wb_dat_i[7:4], sel_w};
            if (wb_sel_i[1])
                ctrl_reg[11:8] <= wb_dat_i[11:8];
            if (wr_auto)
                ab_reg <= sp_pkg::AB_MEAS;
            ab_cnt_reg <= 21'h0;
        end
        else if (auto_on && port_on)
        begin
            case (ab_reg)
                sp_pkg::AB_MEAS:
                    if (!rx_lin)
                        ab_cnt_reg <= ab_cnt_reg + {20'h0, ~&ab_cnt_reg};
                    else if (ab_cnt_reg != 21'h0)
                    begin
                        if (pick[4])
                        begin
                            ctrl_reg[3:0] <= pick[3:0];
                            ab_reg <= sp_pkg::AB_IDLE;
                        end
                        ab_cnt_reg <= 21'h0;
                    end
                sp_pkg::AB_IDLE:
                    // rest of the first character is skipped, not decoded
                    if (!rx_lin)
                        ab_cnt_reg <= 21'h0;
                    else if (ab_cnt_reg >= idle_need)
                        ab_reg <= sp_pkg::AB_DONE;
                    else
                        ab_cnt_reg <= ab_cnt_reg + 21'h1;
                default:
                    ab_cnt_reg <= 21'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_st_reg <= sp_pkg::RX_IDLE;
            rx_cnt_reg <= 17'h0;
            rx_bit_reg <= 3'h0;
            rx_sh_reg <= 8'h0;
            rx_par_reg <= 1'b0;
        end
        else if (!rx_go)
            rx_st_reg <= sp_pkg::RX_IDLE;
        else if (rx_st_reg != sp_pkg::RX_IDLE && rx_cnt_reg != 17'h0)
            rx_cnt_reg <= rx_cnt_reg - 17'h1;
        else
        begin
            rx_cnt_reg <= div;
            case (rx_st_reg)
                sp_pkg::RX_IDLE:
                    if (!rx_lin)
                    begin
                        rx_st_reg <= sp_pkg::RX_START;
                        rx_cnt_reg <= div >> 1;
                    end
                sp_pkg::RX_START:
                begin
                    rx_st_reg <= rx_lin ? sp_pkg::RX_IDLE : sp_pkg::RX_DATA;
                    rx_bit_reg <= 3'h0;
                end
                sp_pkg::RX_DATA:
                begin
                    rx_sh_reg <= {rx_lin, rx_sh_reg[7:1]};
                    rx_bit_reg <= rx_bit_reg + 3'h1;
                    if (rx_bit_reg == nb_m1)
                        rx_st_reg <= par_on ? sp_pkg::RX_PAR
                            : sp_pkg::RX_STOP;
                end
                sp_pkg::RX_PAR:
                begin
                    rx_par_reg <= rx_lin;
                    rx_st_reg <= sp_pkg::RX_STOP;
                end
                default:
                    rx_st_reg <= sp_pkg::RX_IDLE;
            endcase
        end
    end

    // line routing: hold up to four bytes until the prefix is decided
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            route_reg <= sp_pkg::R_HUNT;
            pend_reg <= 32'h0;
            pcnt_reg <= 3'h0;
            flush_reg <= 1'b0;
            fl_loc_reg <= 1'b0;
        end
        else if (byte_in)
        begin
            pend_reg <= pend_reg | ({24'h0, rx_data} << {pcnt_reg, 3'h0});
            pcnt_reg <= pcnt_reg + 3'h1;
            if (cellhost)
            begin
                flush_reg <= 1'b1;
                fl_loc_reg <= 1'b0;
            end
            else if (route_reg != sp_pkg::R_HUNT)
            begin
                flush_reg <= 1'b1;
                fl_loc_reg <= route_reg == sp_pkg::R_LOC;
                if (is_cr)
                    route_reg <= sp_pkg::R_HUNT;
            end
            else if (is_cr || !cmd_ok)
            begin
                flush_reg <= 1'b1;
                fl_loc_reg <= 1'b0;
                if (!is_cr)
                    route_reg <= sp_pkg::R_FWD;
            end
            else if (pcnt_reg == 3'h3)
            begin
                flush_reg <= 1'b1;
                fl_loc_reg <= 1'b1;
                route_reg <= sp_pkg::R_LOC;
            end
        end
        else if (flush_reg)
        begin
            if (pcnt_reg == 3'h0)
                flush_reg <= 1'b0;
            else
            begin
                pend_reg <= pend_reg >> 8;
                pcnt_reg <= pcnt_reg - 3'h1;
            end
        end
    end

    // receive status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_buf_reg <= 8'h0;
            rxv_reg <= 1'b0;
            ovr_reg <= 1'b0;
            perr_reg <= 1'b0;
            ferr_reg <= 1'b0;
            xoff_reg <= 1'b0;
            cell_d_reg <= 8'h0;
            cell_v_reg <= 1'b0;
        end
        else
        begin
            cell_v_reg <= dl_stb && !fl_loc_reg;
            if (dl_stb && !fl_loc_reg)
                cell_d_reg <= pend_reg[7:0];
            if (dl_stb && fl_loc_reg)
                rx_buf_reg <= pend_reg[7:0];
            rxv_reg <= (dl_stb && fl_loc_reg) || (rxv_reg && !rd_rxd);
            ovr_reg <= (dl_stb && fl_loc_reg && rxv_reg && !rd_rxd)
                || (ovr_reg && !(wr_stat && wb_dat_i[5]));
            perr_reg <= (rx_done && rx_perr)
                || (perr_reg && !(wr_stat && wb_dat_i[3]));
            ferr_reg <= (rx_done && !rx_lin)
                || (ferr_reg && !(wr_stat && wb_dat_i[4]));
            if (!sw_flow || (rx_done && is_xon))
                xoff_reg <= 1'b0;
            else if (rx_done && is_xoff)
                xoff_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_st_reg <= sp_pkg::TX_IDLE;
            tx_cnt_reg <= 17'h0;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= 8'h0;
            tx_buf_reg <= 8'h0;
            tx_full_reg <= 1'b0;
            tx_par_reg <= 1'b0;
            rxd_reg <= 1'b1;
        end
        else
        begin
            if (wr_txd && !tx_full_reg)
            begin
                tx_buf_reg <= wb_dat_i[7:0];
                tx_full_reg <= 1'b1;
            end
            if (!port_on)
            begin
                tx_st_reg <= sp_pkg::TX_IDLE;
                rxd_reg <= 1'b1;
            end
            else if (tx_st_reg != sp_pkg::TX_IDLE && tx_cnt_reg != 17'h0)
                tx_cnt_reg <= tx_cnt_reg - 17'h1;
            else
            begin
                tx_cnt_reg <= div;
                case (tx_st_reg)
                    sp_pkg::TX_IDLE:
                        if (tx_full_reg && tx_ok)
                        begin
                            tx_st_reg <= sp_pkg::TX_START;
                            tx_sh_reg <= tx_mask;
                            tx_par_reg <= ^tx_mask ^ par_odd;
                            tx_full_reg <= 1'b0;
                            rxd_reg <= 1'b0;
                        end
                    sp_pkg::TX_START:
                    begin
                        tx_st_reg <= sp_pkg::TX_DATA;
                        tx_bit_reg <= 3'h0;
                        rxd_reg <= tx_sh_reg[0];
                    end
                    sp_pkg::TX_DATA:
                        if (tx_bit_reg != nb_m1)
                        begin
                            tx_bit_reg <= tx_bit_reg + 3'h1;
                            tx_sh_reg <= tx_sh_reg >> 1;
                            rxd_reg <= tx_sh_reg[1];
                        end
                        else
                        begin
                            tx_st_reg <= par_on ? sp_pkg::TX_PAR
                                : sp_pkg::TX_STOP;
                            rxd_reg <= par_on ? tx_par_reg : 1'b1;
                            tx_bit_reg <= {2'h0, stop2};
                        end
                    sp_pkg::TX_PAR:
                    begin
                        tx_st_reg <= sp_pkg::TX_STOP;
                        rxd_reg <= 1'b1;
                        tx_bit_reg <= {2'h0, stop2};
                    end
                    default:
                        if (tx_bit_reg != 3'h0)
                            tx_bit_reg <= tx_bit_reg - 3'h1;
                        else
                            tx_st_reg <= sp_pkg::TX_IDLE;
                endcase
            end
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    sequence s_load;
        tx_st_reg == sp_pkg::TX_IDLE ##1 tx_st_reg == sp_pkg::TX_START;
    endsequence
    property p_start;
        s_load |-> !rxd_n_o ##1 !rxd_n_o;
    endproperty
    a_start: assert property (p_start) else $error("no start bit");
    property p_hold;
        tx_st_reg == sp_pkg::TX_IDLE && (dtr_lvl || rts_lvl)
            |=> tx_st_reg == sp_pkg::TX_IDLE;
    endproperty
    a_hold: assert property (p_hold) else $error("sent while held");
    property p_sleep;
        sleep_i |=> cts_n_o && rxd_n_o && rx_st_reg == sp_pkg::RX_IDLE;
    endproperty
    a_sleep: assert property (p_sleep) else $error("active asleep");
    property p_hwcts;
        flow == sp_pkg::FLOW_HW && rxv_reg |=> cts_n_o;
    endproperty
    a_hwcts: assert property (p_hwcts) else $error("cts low when full");
    property p_par;
        tx_st_reg == sp_pkg::TX_PAR |-> par_on;
    endproperty
    a_par: assert property (p_par) else $error("parity bit unasked");
    property p_auto;
        $rose(locked) |-> sel <= sp_pkg::SEL_AUTO_MAX;
    endproperty
    a_auto: assert property (p_auto) else $error("autobaud too fast");
    property p_rate;
        sel <= sp_pkg::SEL_MAX;
    endproperty
    a_rate: assert property (p_rate) else $error("rate out of table");
    property p_cell;
        byte_in && cellhost |=> !fl_loc_reg ##1 !rxv_reg || $stable(rx_buf_reg);
    endproperty
    a_cell: assert property (p_cell) else $error("kept a byte locally");
    property p_fwd;
        dl_stb && !fl_loc_reg |=> cell_valid_o
            && cell_data_o == $past(pend_reg[7:0]);
    endproperty
    a_fwd: assert property (p_fwd) else $error("byte not forwarded");
    property p_ack;
        hit |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bad bus answer");
endmodule
`default_nettype wire

// >>> sp_pkg.sv
// Purpose: shared constants and types of the primary serial port
// Assumes: 250 MHz system clock, 32-bit classic Wishbone register bus
// Notes: byte offsets, ctrl field positions, reset values, codes
package sp_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int NRATE = 11;
    localparam int RATE_TAB [NRATE] = '{2400, 4800, 9600, 19200, 38400,
        57600, 115200, 230400, 1000000, 1500000, 3000000};
    localparam logic [3:0] SEL_AUTO_MAX = 4'h6;
    localparam logic [3:0] SEL_MAX = 4'ha;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_TXD = 8'h08;
    localparam logic [7:0] ADR_RXD = 8'h0c;
    localparam logic [7:0] ADR_MODEM = 8'h10;
    localparam int C_AUTO = 4;
    localparam int C_FLOW = 5;
    localparam int C_PAR = 7;
    localparam int C_STOP2 = 9;
    localparam int C_DATA7 = 10;
    localparam int C_CELLHOST = 11;
    localparam logic [11:0] CTRL_RST = 12'h036;
    localparam logic [1:0] FLOW_HW = 2'h1;
    localparam logic [1:0] FLOW_SW = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [2:0] MODEM_RST = 3'h1;
    localparam logic [7:0] STAT_W1C = 8'h38;
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CASE_BIT = 8'h20;
    localparam logic [31:0] CMD_PREFIX = 32'h692b7461;
    localparam logic [20:0] AB_NUM = 21'h3;
    localparam int AB_SHIFT = 2;
    localparam logic [20:0] AB_IDLE_BITS = 21'ha;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
        rx_st_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
        tx_st_t;
    typedef enum logic [1:0] {R_HUNT, R_LOC, R_FWD} route_t;
    typedef enum logic [1:0] {AB_MEAS, AB_IDLE, AB_DONE} ab_t;
endpackage

// >>> host_term.sv
// Purpose: host terminal model on the primary serial port
// Assumes: bit length given in clocks; device sends lsb first
// Notes: txd idles high, as the pulled-up line does
`timescale 1ns/1ns
`default_nettype none
module host_term (
    input wire logic clk_sys_i,
    input wire logic rxd_n_i,
    output logic txd_n_o,
    output logic rts_n_o,
    output logic dtr_n_o
);
    initial
    begin
        txd_n_o = 1'b1;
        rts_n_o = 1'b0;
        dtr_n_o = 1'b0;
    end
    task automatic send(input int bc, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk_sys_i);
            txd_n_o <= f[i];
            repeat (bc - 1) @(posedge clk_sys_i);
        end
    endtask
    // samples mid-bit; ok low means no start bit within lim cycles
    task automatic rcv(input int bc, input int n, input int lim,
        output logic [11:0] v, output logic ok);
        int k;
        v = '0;
        ok = 1'b0;
        k = 0;
        while (rxd_n_i !== 1'b0 && k < lim)
        begin
            @(posedge clk_sys_i);
            k++;
        end
        if (k < lim)
        begin
            ok = 1'b1;
            repeat (bc / 2) @(posedge clk_sys_i);
            for (int i = 0; i < n; i++)
            begin
                repeat (bc) @(posedge clk_sys_i);
                v[i] = rxd_n_i;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> primary_dce_uart_bench.sv
// Purpose: self-checking bench of the primary serial port
// Assumes: model clock 25 MHz, so 115200 bit/s is 217 cycles a bit; the host uses 218
// Notes: bus requests held until ack, two idle cycles between
`timescale 1ns/1ns
`default_nettype none
module primary_dce_uart_bench;
    localparam int BC = 218;
    // post-wake settling wait, cut far short to keep the run brief
    localparam int WAKE = 1000;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic sleep_i = 1'b0;
    logic [31:0] rdat;
    logic ack, txd_n, rts_n, dtr_n, rxd_n, cts_n, dsr_n, car_n, ring_n;
    logic [7:0] cell_d;
    logic cell_v;
    logic [31:0] q;
    logic [11:0] v;
    logic ok;
    logic [7:0] cq[$];
    int error_cnt = 0;
    int checked = 0;
    primary_serial_port #(.clk_hz_p(25_000_000)) primary_serial_port_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sleep_i(sleep_i), .txd_n_i(txd_n),
        .rts_n_i(rts_n), .dtr_n_i(dtr_n), .rxd_n_o(rxd_n),
        .cts_n_o(cts_n), .dsr_n_o(dsr_n),
        .carrier_present_out_n_o(car_n), .ring_indicate_out_n_o(ring_n),
        .cell_data_o(cell_d), .cell_valid_o(cell_v));
    host_term host_term_i (.clk_sys_i(clk_sys_i), .rxd_n_i(rxd_n),
        .txd_n_o(txd_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n));
    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
    begin
        if (cell_v === 1'b1)
            cq.push_back(cell_d);
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        @(posedge clk_sys_i);
        if (n >= 50)
        begin
            error_cnt++;
            results();
        end
    endtask
    // queue cleared first so each line is judged on its own bytes
    task automatic line(input string s);
        cq.delete();
        for (int i = 0; i < s.len(); i++)
            host_term_i.send(BC, s[i]);
        repeat (20) @(posedge clk_sys_i);
    endtask
    task automatic t_reset;
        wb(0, sp_pkg::ADR_CTRL, 0);
        chk("ctrl", q, 32'h36);
        chk("rxd_idle", rxd_n, 1'b1);
        chk("cts_rst", cts_n, 1'b0);
        wb(0, 8'h14, 0);
        chk("unmapped", q, 32'h0);
        chk("pins", {dsr_n, car_n, ring_n}, 3'h3);
        wb(1, sp_pkg::ADR_MODEM, 32'h6);
        repeat (2) @(posedge clk_sys_i);
        chk("pins", {dsr_n, car_n, ring_n}, 3'h4);
        $display("reset done");
    endtask
    task automatic t_route;
        wb(1, sp_pkg::ADR_CTRL, 32'h30);
        line("A");
        repeat (BC * 11) @(posedge clk_sys_i);
        wb(0, sp_pkg::ADR_STAT, 0);
        chk("locked", q[2], 1'b1);
        wb(0, sp_pkg::ADR_CTRL, 0);
        chk("rate", q[3:0], 4'h6);
        line("AtZ\015");
        chk("fwd_n", cq.size(), 4);
        chk("fwd", {cq[0], cq[1], cq[2], cq[3]}, "AtZ\015");
        line("aT+i\015");
        chk("nofwd", cq.size(), 0);
        chk("cts", cts_n, 1'b1);
        wb(0, sp_pkg::ADR_RXD, 0);
        chk("rxd", q, 32'h0d);
        repeat (4) @(posedge clk_sys_i);
        chk("cts", cts_n, 1'b0);
        wb(1, sp_pkg::ADR_CTRL, 32'h826);
        line("at");
        chk("cell_n", cq.size(), 2);
        chk("cell", {cq[0], cq[1]}, "at");
        $display("route done");
    endtask
    // a held character must go out once terminal-ready returns
    task automatic t_tx;
        wb(1, sp_pkg::ADR_CTRL, 32'h2a6);
        host_term_i.dtr_n_o <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        wb(1, sp_pkg::ADR_TXD, 32'h5a);
        host_term_i.rcv(BC, 11, BC * 4, v, ok);
        chk("held", ok, 1'b0);
        host_term_i.dtr_n_o <= 1'b0;
        host_term_i.rcv(BC, 11, BC * 4, v, ok);
        chk("even2", {ok, v}, 13'h165a);
        wb(1, sp_pkg::ADR_CTRL, 32'h126);
        wb(1, sp_pkg::ADR_TXD, 32'h5a);
        host_term_i.rcv(BC, 10, BC * 4, v, ok);
        chk("odd1", {ok, v}, 13'h135a);
        wb(1, sp_pkg::ADR_CTRL, 32'h46);
        cq.delete();
        host_term_i.send(BC, sp_pkg::CH_XOFF);
        wb(0, sp_pkg::ADR_STAT, 0);
        chk("xoff", q[7], 1'b1);
        wb(1, sp_pkg::ADR_TXD, 32'ha5);
        host_term_i.rcv(BC, 9, BC * 4, v, ok);
        chk("xoff_hold", ok, 1'b0);
        // the held byte leaves during the stop bit of the xon frame
        fork
            host_term_i.send(BC, sp_pkg::CH_XON);
            host_term_i.rcv(BC, 9, BC * 16, v, ok);
        join
        chk("xon", {ok, v}, 13'h11a5);
        chk("xq", cq.size(), 0);
        wb(1, sp_pkg::ADR_CTRL, 32'h426);
        wb(1, sp_pkg::ADR_TXD, 32'h5a);
        host_term_i.rcv(BC, 9, BC * 4, v, ok);
        chk("data7", {ok, v}, 13'h11da);
        $display("tx done");
    endtask
    task automatic t_sleep;
        wb(1, sp_pkg::ADR_CTRL, 32'h26);
        sleep_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        chk("cts", cts_n, 1'b1);
        wb(0, sp_pkg::ADR_STAT, 0);
        chk("sleep", q[6], 1'b1);
        line("z");
        chk("asleep", cq.size(), 0);
        sleep_i <= 1'b0;
        repeat (WAKE) @(posedge clk_sys_i);
        chk("cts_wake", cts_n, 1'b0);
        line("z");
        chk("awake_n", cq.size(), 1);
        chk("awake", cq[0], "z");
        $display("sleep done");
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        t_route();
        t_tx();
        t_sleep();
        results();
    end
endmodule
`default_nettype wire
